/* core/tcm_timer.sv */
// Behaviour
// - Action field picks latch state at next match and pin source
// - Reset clears the waveform output latch to zero
// - Nonzero action field replaces port value with latch; direction bit unchanged
// - Latch reaches pin only when direction bit selects output
// - Override depends only on action field, not on mode
// - Zero action field leaves latch unchanged at matches
// - New action value first acts at next match, not at write
// - Force strobe applies action immediately in non-PWM modes
// - Mode select alone picks counting; action field only shapes output
// - Normal mode counts up, wraps 0xff to 0x00, never match-cleared
// - Normal mode sets overflow flag when count wraps from 0xff to zero
// - Overflow interrupt service clears overflow flag in hardware
// - Normal mode accepts count writes any time
// - Clear-on-match mode clears counter when it equals compare A
// - Compare A flag marks each time counter reaches top
// - Compare A unbuffered; a value below count misses until wrap
// - Action 1 in clear-on-match mode toggles latch each match
// - Toggle frequency is clk over 2*N*(1+compare)
// - Clear-on-match mode sets overflow flag on max to zero
// - Compare flag sets one tick after match; clears by service or one
// - Count write blocks compare matches in the following timer tick
// - Clock select zero stops counter; processor write beats counting
`default_nettype none
module tcm_timer
    import tcm_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        tick_i,
    input  wire logic        ovf_ack_i,
    input  wire logic        cmpa_ack_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             pin_o,
    output logic             pin_oe_o,
    output logic             overflow_flag_o,
    output logic             compare_a_flag_o
);
    // ********************************************
    // Register state
    // ********************************************
    logic [1:0]  compare_a_output_action_r;
    logic [2:0]  waveform_mode_select_r;
    logic [2:0]  clock_source_select_r;
    logic        waveform_pin_direction_bit_r;
    logic        port_value_r;
    logic [7:0]  count_value_r;
    logic [7:0]  compare_a_value_r;
    logic        overflow_flag_r;
    logic        compare_a_flag_r;
    logic        waveform_output_latch_r;
    logic        match_pend_r;
    logic        block_r;
    logic [31:0] rd_data;
    logic        wr;
    logic        run;
    logic        match;
    logic        force_compare_strobe;
    logic        ovf_evt;
    logic [7:0]  count_nxt;
    logic        cnt_wr;
    logic [7:0]  wr_byte;

    // ********************************************
    // Wishbone slave, one wait state free ack
    // ********************************************
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign force_compare_strobe = wr && wb_adr_i == TCM_CTRL_OFS && wb_sel_i[1]
                                  && wb_dat_i[TCM_FOC_BIT];
    // Strobe acts with the action held before this write, not the one it carries
    assign cnt_wr  = wr && wb_adr_i == TCM_COUNT_OFS && wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            TCM_CTRL_OFS:
            begin
                rd_data[TCM_ACT_LSB +: 2]  = compare_a_output_action_r;
                rd_data[TCM_MODE_LSB +: 3] = waveform_mode_select_r;
                rd_data[TCM_CS_LSB +: 3]   = clock_source_select_r;
                rd_data[TCM_DIR_BIT]       = waveform_pin_direction_bit_r;
                rd_data[TCM_PORT_BIT]      = port_value_r;
            end
            TCM_COUNT_OFS: rd_data[7:0] = count_value_r;
            TCM_CMPA_OFS:  rd_data[7:0] = compare_a_value_r;
            TCM_FLAG_OFS:
            begin
                rd_data[TCM_OVF_BIT]  = overflow_flag_r;
                rd_data[TCM_CMPF_BIT] = compare_a_flag_r;
                rd_data[TCM_OUT_BIT]  = waveform_output_latch_r;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
            wb_dat_o <= rd_data;
    end

    // Action field change alone never touches the latch
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            compare_a_output_action_r    <= 2'h0;
            waveform_mode_select_r       <= TCM_MODE_NORMAL;
            clock_source_select_r        <= 3'h0;
            waveform_pin_direction_bit_r <= 1'b0;
            port_value_r                 <= 1'b0;
        end
        else if (wr && wb_adr_i == TCM_CTRL_OFS)
        begin
            if (wb_sel_i[0])
            begin
                compare_a_output_action_r <= wb_dat_i[TCM_ACT_LSB +: 2];
                waveform_mode_select_r    <= wb_dat_i[TCM_MODE_LSB +: 3];
                clock_source_select_r     <= wb_dat_i[TCM_CS_LSB +: 3];
            end
            if (wb_sel_i[1])
            begin
                waveform_pin_direction_bit_r <= wb_dat_i[TCM_DIR_BIT];
                port_value_r                 <= wb_dat_i[TCM_PORT_BIT];
            end
        end
    end

    // Unbuffered: a new top below the count is missed until wrap
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            compare_a_value_r <= TCM_CMPA_RST;
        else if (wr && wb_adr_i == TCM_CMPA_OFS && wb_sel_i[0])
            compare_a_value_r <= wb_dat_i[7:0];
    end

    // ********************************************
    // Counter
    // ********************************************
    assign run   = tick_i && clock_source_select_r != 3'h0;
    assign match = count_value_r == compare_a_value_r && !block_r;

    always_comb
    begin
        // A blocked match must not clear the counter either
        if (waveform_mode_select_r == TCM_MODE_CLEAR && match)
            count_nxt = TCM_COUNT_RST;
        else
            count_nxt = count_value_r + 8'h01;
    end
    assign ovf_evt = run && count_value_r == TCM_COUNT_MAX && count_nxt == 8'h00;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count_value_r <= TCM_COUNT_RST;
        else if (wr && wb_adr_i == TCM_COUNT_OFS && wb_sel_i[0])
            count_value_r <= wb_dat_i[7:0];
        else if (run)
            count_value_r <= count_nxt;
    end

    // Block lasts until one timer tick passes, even while stopped
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            block_r <= 1'b0;
        else if (wr && wb_adr_i == TCM_COUNT_OFS && wb_sel_i[0])
            block_r <= 1'b1;
        else if (tick_i)
            block_r <= 1'b0;
    end

    // ********************************************
    // Flags; set wins over clear
    // ********************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            match_pend_r <= 1'b0;
        else if (tick_i)
            match_pend_r <= match && clock_source_select_r != 3'h0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            overflow_flag_r <= 1'b0;
        else if (ovf_evt)
            overflow_flag_r <= 1'b1;
        else if (ovf_ack_i || (wr && wb_adr_i == TCM_FLAG_OFS && wb_sel_i[0]
                 && wb_dat_i[TCM_OVF_BIT]))
            overflow_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            compare_a_flag_r <= 1'b0;
        else if (tick_i && match_pend_r)
            compare_a_flag_r <= 1'b1;
        else if (cmpa_ack_i || (wr && wb_adr_i == TCM_FLAG_OFS && wb_sel_i[0]
                 && wb_dat_i[TCM_CMPF_BIT]))
            compare_a_flag_r <= 1'b0;
    end

    // ********************************************
    // Waveform output latch and pin
    // ********************************************
    // Toggle on each match gives clk/(2*N*(1+compare))
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            waveform_output_latch_r <= 1'b0;
        else if ((run && match) || force_compare_strobe)
        begin
            unique case (compare_a_output_action_r)
                TCM_ACT_TOGGLE: waveform_output_latch_r <= !waveform_output_latch_r;
                TCM_ACT_CLEAR:  waveform_output_latch_r <= 1'b0;
                TCM_ACT_SET:    waveform_output_latch_r <= 1'b1;
                default:        waveform_output_latch_r <= waveform_output_latch_r;
            endcase
        end
    end

    // Mode is not looked at here on purpose
    assign pin_o = (compare_a_output_action_r != 2'h0) ? waveform_output_latch_r
                                                       : port_value_r;
    assign pin_oe_o = waveform_pin_direction_bit_r;
    assign overflow_flag_o  = overflow_flag_r;
    assign compare_a_flag_o = compare_a_flag_r;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_cnt_write;
        cnt_wr;
    endsequence

    sequence s_match_tick;
        tick_i && match && clock_source_select_r != 3'h0;
    endsequence

    sequence s_flag_pend;
        tick_i && match_pend_r;
    endsequence

    // ********************************************
    // Checks on the pin and the latch
    // ********************************************
    chk_latch_reset: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |-> !waveform_output_latch_r)
        else $error("latch not cleared by reset");
    chk_pin_override_src: assert property (
        compare_a_output_action_r != 2'h0 |-> pin_o == waveform_output_latch_r)
        else $error("pin not driven from latch");
    chk_pin_port_src: assert property (
        compare_a_output_action_r == 2'h0 |-> pin_o == port_value_r)
        else $error("pin not driven from port value");
    chk_pin_dir_gate: assert property (
        pin_oe_o == waveform_pin_direction_bit_r)
        else $error("pin enable differs from direction bit");
    chk_latch_no_action: assert property (
        compare_a_output_action_r == 2'h0 |=> $stable(waveform_output_latch_r))
        else $error("latch moved with zero action");
    // Only a match or the strobe may move the latch
    chk_latch_hold: assert property (
        !force_compare_strobe && !(run && match) |=> $stable(waveform_output_latch_r))
        else $error("latch moved without match or strobe");
    chk_force_set: assert property (
        force_compare_strobe && compare_a_output_action_r == TCM_ACT_SET
        |=> waveform_output_latch_r)
        else $error("strobe did not set latch");
    chk_force_clear: assert property (
        force_compare_strobe && compare_a_output_action_r == TCM_ACT_CLEAR
        |=> !waveform_output_latch_r)
        else $error("strobe did not clear latch");
    chk_ctc_toggle: assert property (
        run && match && compare_a_output_action_r == TCM_ACT_TOGGLE && !force_compare_strobe
        |=> waveform_output_latch_r != $past(waveform_output_latch_r))
        else $error("latch did not toggle on match");

    // ********************************************
    // Checks on the counter
    // ********************************************
    chk_normal_step: assert property (
        run && waveform_mode_select_r == TCM_MODE_NORMAL && !cnt_wr
        |=> count_value_r == $past(count_value_r) + 8'h01)
        else $error("normal mode did not count up");
    chk_normal_wrap_ovf: assert property (
        run && waveform_mode_select_r == TCM_MODE_NORMAL && count_value_r == 8'hff
        && !cnt_wr |=> count_value_r == 8'h00 && overflow_flag_r)
        else $error("normal wrap without overflow");
    chk_ovf_at_max: assert property (
        $rose(overflow_flag_r) |-> $past(count_value_r) == TCM_COUNT_MAX)
        else $error("overflow flag rose away from max");
    chk_count_write: assert property (
        s_cnt_write |=> count_value_r == $past(wr_byte))
        else $error("count write did not land");
    chk_ctc_clear_top: assert property (
        run && waveform_mode_select_r == TCM_MODE_CLEAR && match && !cnt_wr
        |=> count_value_r == 8'h00)
        else $error("clear mode did not clear at top");
    // Unbuffered top: a value below the count is passed over
    chk_ctc_miss: assert property (
        run && waveform_mode_select_r == TCM_MODE_CLEAR
        && count_value_r != compare_a_value_r && !cnt_wr
        |=> count_value_r == $past(count_value_r) + 8'h01)
        else $error("clear mode left the count sequence");
    chk_ctc_wrap_ovf: assert property (
        run && waveform_mode_select_r == TCM_MODE_CLEAR && count_value_r == TCM_COUNT_MAX
        && !cnt_wr |=> count_value_r == 8'h00 && overflow_flag_r)
        else $error("clear mode wrap without overflow");
    chk_write_blocks: assert property (
        s_cnt_write |=> !match)
        else $error("match not blocked after count write");
    chk_stop_hold: assert property (
        clock_source_select_r == 3'h0 && !cnt_wr |=> $stable(count_value_r))
        else $error("counter moved while stopped");
    chk_count_tick: assert property (
        !tick_i && !cnt_wr |=> $stable(count_value_r))
        else $error("counter moved without a tick");

    // ********************************************
    // Checks on the flags
    // ********************************************
    chk_ovf_ack: assert property (
        ovf_ack_i && !ovf_evt |=> !overflow_flag_r)
        else $error("overflow flag kept after service");
    chk_match_pending: assert property (
        s_match_tick |=> match_pend_r)
        else $error("match not held for the next tick");
    chk_cmp_flag_late: assert property (
        s_flag_pend |=> compare_a_flag_r)
        else $error("compare flag not set a tick later");
    chk_cmpf_rise: assert property (
        $rose(compare_a_flag_r) |-> $past(match_pend_r) && $past(tick_i))
        else $error("compare flag rose without a pending match");
    chk_cmpf_ack: assert property (
        cmpa_ack_i && !(tick_i && match_pend_r) |=> !compare_a_flag_r)
        else $error("compare flag kept after service");
    chk_cmpf_w1c: assert property (
        wr && wb_adr_i == TCM_FLAG_OFS && wb_sel_i[0] && wb_dat_i[TCM_CMPF_BIT]
        && !(tick_i && match_pend_r) |=> !compare_a_flag_r)
        else $error("compare flag kept after write of one");
    chk_flag_tick: assert property (
        !tick_i |=> !$rose(overflow_flag_r) && !$rose(compare_a_flag_r))
        else $error("flag set without a tick");

    // ********************************************
    // Checks on the bus
    // ********************************************
    // Ack is a single pulse, so a request held past it is taken again two cycles after the first
    chk_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for two cycles");
endmodule
`default_nettype wire

/* core/tcm_pkg.sv */
`default_nettype none
package tcm_pkg;
    // ********************************************
    // Register offsets (byte addresses)
    // ********************************************
    localparam logic [3:0] TCM_CTRL_OFS  = 4'h0;
    localparam logic [3:0] TCM_COUNT_OFS = 4'h4;
    localparam logic [3:0] TCM_CMPA_OFS  = 4'h8;
    localparam logic [3:0] TCM_FLAG_OFS  = 4'hc;
    // ********************************************
    // Control and flag field positions
    // ********************************************
    localparam int TCM_ACT_LSB  = 0;
    localparam int TCM_MODE_LSB = 2;
    localparam int TCM_CS_LSB   = 5;
    localparam int TCM_FOC_BIT  = 8;
    localparam int TCM_DIR_BIT  = 9;
    localparam int TCM_PORT_BIT = 10;
    localparam int TCM_OVF_BIT  = 0;
    localparam int TCM_CMPF_BIT = 1;
    localparam int TCM_OUT_BIT  = 2;
    // ********************************************
    // Modes and reset values
    // ********************************************
    localparam logic [2:0] TCM_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TCM_MODE_CLEAR  = 3'h2;
    localparam logic [7:0] TCM_COUNT_RST   = 8'h00;
    localparam logic [7:0] TCM_CMPA_RST    = 8'h00;
    localparam logic [7:0] TCM_COUNT_MAX   = 8'hff;
    localparam logic [1:0] TCM_ACT_TOGGLE  = 2'h1;
    localparam logic [1:0] TCM_ACT_CLEAR   = 2'h2;
    localparam logic [1:0] TCM_ACT_SET     = 2'h3;
endpackage
`default_nettype wire

/* verif/tcm_pin_load.sv */
`default_nettype none
module tcm_pin_load
(
    input  wire logic pin_i,
    input  wire logic oe_i,
    output logic      pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************
    // Pad with weak pull-down load
    // ****************************
    // Undriven pad sinks to the pull-down, never keeps the last value
    assign pad_o = oe_i ? pin_i : 1'b0;
endmodule
`default_nettype wire

/* verif/tcm_timer_tb.sv */
`default_nettype none
module tcm_timer_tb
    import tcm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, tick, ovf_ack, cmpa_ack, cyc, stb, we;
    logic [3:0]  adr, sel;
    logic [31:0] dat_w, dat_r, rd, lfsr;
    logic        ack, pin, pin_oe, ovf_f, cmpa_f, pad;
    int          num_errors, cmp_count;
    int          cnt, cmpa, act, mode, cs, lat, ovf, cmpf, pf, blk, dir, prt, pact;

    tcm_timer DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .tick_i(tick), .ovf_ack_i(ovf_ack),
        .cmpa_ack_i(cmpa_ack), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .pin_o(pin),
        .pin_oe_o(pin_oe), .overflow_flag_o(ovf_f), .compare_a_flag_o(cmpa_f));
    tcm_pin_load LOAD (.pin_i(pin), .oe_i(pin_oe), .pad_o(pad));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************
    // Model and bus tasks
    // ****************************
    function automatic logic [31:0] nxt(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction
    function automatic int ap(input int a, input int l);
        return (a == 1) ? 1 - l : (a == 2) ? 0 : (a == 3) ? 1 : l;
    endfunction
    function automatic logic [31:0] ctl(input int f);
        return 32'((act << TCM_ACT_LSB) | (mode << TCM_MODE_LSB) | (cs << TCM_CS_LSB)
            | (f << TCM_FOC_BIT) | (dir << TCM_DIR_BIT) | (prt << TCM_PORT_BIT));
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ack is read before the edge's own updates land, so it is the sampled value
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            num_errors++;
            end_sim();
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wctl(input int f);
        bus(1'b1, TCM_CTRL_OFS, ctl(f));
        // Strobe acts with the action held before this write
        if (f != 0) lat = ap(pact, lat);
        pact = act;
    endtask
    task automatic wcnt(input int v);
        bus(1'b1, TCM_COUNT_OFS, 32'(v));
        cnt = v;
        blk = 1;
    endtask
    task automatic wcmp(input int v);
        bus(1'b1, TCM_CMPA_OFS, 32'(v));
        cmpa = v;
    endtask
    task automatic ccnt();
        bus(1'b0, TCM_COUNT_OFS, 32'h0);
        chk("count", 32'(cnt), rd);
    endtask
    task automatic cfl();
        bus(1'b0, TCM_FLAG_OFS, 32'h0);
        chk("ovf", 32'(ovf), 32'(rd[TCM_OVF_BIT]));
        chk("cmpf", 32'(cmpf), 32'(rd[TCM_CMPF_BIT]));
        chk("latch", 32'(lat), 32'(rd[TCM_OUT_BIT]));
        chk("ovf_o", 32'(ovf), 32'(ovf_f));
        chk("cmpf_o", 32'(cmpf), 32'(cmpa_f));
        chk("pin_o", 32'((act != 0) ? lat : prt), 32'(pin));
        chk("pad", 32'(dir ? ((act != 0) ? lat : prt) : 0), 32'(pad));
        chk("pin_oe", 32'(dir), 32'(pin_oe));
    endtask
    // Model counts only when the timer runs; the flag lags its match by one tick
    task automatic tk(input int n);
        int m;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            tick <= 1'b1;
            if (cs != 0)
            begin
                m = (cnt == cmpa && blk == 0);
                if (pf) cmpf = 1;
                pf = m;
                if (cnt == 255) ovf = 1;
                cnt = (mode == 2 && m) ? 0 : (cnt + 1) % 256;
                if (m) lat = ap(act, lat);
            end
            blk = 0;
        end
        @(posedge clk);
        tick <= 1'b0;
    endtask
    task automatic ackp(input logic o, input logic c);
        @(posedge clk);
        ovf_ack <= o;
        cmpa_ack <= c;
        @(posedge clk);
        ovf_ack <= 1'b0;
        cmpa_ack <= 1'b0;
        if (o) ovf = 0;
        if (c) cmpf = 0;
    endtask
    // ****************************
    // Scenarios
    // ****************************
    initial
    begin
        {rst_n, tick, ovf_ack, cmpa_ack, cyc, stb, we} = '0;
        {adr, dat_w, rd, num_errors, cmp_count} = '0;
        {cnt, cmpa, act, mode, cs, lat, ovf, cmpf, pf, blk, dir, prt, pact} = '0;
        sel = 4'hf;
        lfsr = 32'h9dbf;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cfl();
        for (int k = 0; k < 16; k++)
        begin
            act = k % 4;
            mode = k[2] ? 2 : 0;
            dir = k / 8;
            lfsr = nxt(lfsr);
            prt = lfsr[0];
            wctl(1);
            cfl();
        end
        act = 1;
        wctl(0);
        cfl();
        act = 0;
        mode = 0;
        cs = 1;
        dir = 1;
        wctl(0);
        wcmp('h80);
        wcnt('hfd);
        tk(3);
        ccnt();
        cfl();
        tk(2);
        ccnt();
        ackp(1'b1, 1'b0);
        cfl();
        repeat (4)
        begin
            lfsr = nxt(lfsr);
            wcnt(lfsr[7:0]);
            ccnt();
        end
        act = 1;
        mode = 2;
        wctl(0);
        wcmp(3);
        bus(1'b1, TCM_FLAG_OFS, 32'h3);
        ovf = 0;
        cmpf = 0;
        wcnt(0);
        tk(6);
        ccnt();
        cfl();
        ackp(1'b0, 1'b1);
        cfl();
        tk(4);
        bus(1'b1, TCM_FLAG_OFS, 32'h2);
        cmpf = 0;
        cfl();
        wcnt(10);
        wcmp(5);
        tk(246);
        cfl();
        ccnt();
        wcmp(7);
        wcnt(7);
        tk(1);
        ccnt();
        cs = 0;
        wctl(0);
        tk(5);
        ccnt();
        wcnt('h42);
        ccnt();
        end_sim();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
